//--- watchdog_nmi_timer_tb_top.sv
// Purpose: self-checking bench of the watchdog nmi timer
// Assumes: PRESC_DIV 2, slow pin toggles every 2 clocks
// Notes: one timeout is 2048 slow edges, some 8200 clocks
`timescale 1ns/10ps
`default_nettype none
module watchdog_nmi_timer_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic osc = 1'b0;
  logic div = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic load_sp = 1'b0;
  logic [3:0] ack_wait = 4'hF;
  logic rdy, resp, irq, nreq, hrel, sp1, sp2, ack;
  logic [31:0] rdata, r, d;
  logic [15:0] vec, vtk;
  int taken, edges = 0, base = 0, m_en = 1;
  int errors = 0, checks_done = 0, seed = 32'hBE01;
  always #25 clk = ~clk;
  // ---------------------------------------------------------------
  // slow oscillator and edge model
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    div <= ~div;
    if (div) begin
      osc <= ~osc;
      if (!osc && m_en != 0) edges <= edges + 1;
    end
  end
  wdnmi_top #(.PRESC_DIV(2)) wdnmi_top_inst (.i_clk(clk), .i_reset(rst),
    .i_low_speed_oscillator(osc), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(rdy), .o_hreadyout(rdy), .o_hresp(resp),
    .o_hrdata(rdata), .i_stack_pointer_one_wr(sp1),
    .i_stack_pointer_two_wr(sp2), .i_nmi_ack(ack), .o_nmi_request(nreq),
    .o_halt_release(hrel), .o_nmi_vector(vec), .o_irq(irq));
  wdnmi_cpu_model wdnmi_cpu_model_inst (.i_clk(clk), .i_reset(rst),
    .i_nmi_request(nreq), .i_nmi_vector(vec), .i_load_sp(load_sp),
    .i_ack_wait(ack_wait), .o_sp1_wr(sp1), .o_sp2_wr(sp2), .o_nmi_ack(ack),
    .o_vector_taken(vtk), .o_taken(taken));
  task automatic complete_run;
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic bus(input logic w, input logic [31:0] a, dt);
    int k;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    k = 0;
    do begin @(posedge clk); k++; end while (rdy !== 1'b1 && k < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dt;
    // read data and response are taken at the edge that ends the data phase
    do begin @(posedge clk); k++; end while (rdy !== 1'b1 && k < 40);
    r = rdata;
    check("hresp", 32'h0, {31'h0, resp});
    if (k >= 40) begin errors++; complete_run(); end
  endtask : bus
  task automatic rd(input logic [31:0] a, e, input string nm);
    bus(1'b0, a, 32'h0);
    check(nm, e, r);
  endtask : rd
  // waits on the interrupt line, or on the cpu taking nmi number t
  task automatic wait_ev(input int t, lo, hi);
    int k;
    k = 0;
    while ((t == 0 ? irq !== 1'b1 : taken != t) && k < 12000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 12000) begin errors++; complete_run(); end
    check("edges", 1, edges - base >= lo && edges - base <= hi);
  endtask : wait_ev
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(wdnmi_pkg::CTRL_ADDR, 32'h2, "ctrl");
    rd(wdnmi_pkg::STS_ADDR, 32'h0, "sts");
    rd(wdnmi_pkg::MSK_ADDR, 32'h0, "msk");
    rd(wdnmi_pkg::CTRL_ADDR + 32'h40, 32'h0, "unmapped");
    repeat (4) begin
      d = $random(seed);
      bus(1'b1, wdnmi_pkg::CTRL_ADDR, d);
      m_en = d[1];
      rd(wdnmi_pkg::CTRL_ADDR, {30'h0, d[1], 1'b0}, "ctrl");
    end
    bus(1'b1, wdnmi_pkg::MSK_ADDR, 32'h1);
    repeat (3) begin
      bus(1'b1, wdnmi_pkg::CTRL_ADDR, 32'h3);
      base = edges;
      m_en = 1;
      repeat (6000) @(posedge clk);
      check("early irq", 0, irq);
    end
    bus(1'b1, wdnmi_pkg::CTRL_ADDR, 32'h2); // clear bit 0 ignored
    wait_ev(0, 2046, 2050);
    check("nmi before sp", 0, nreq);
    load_sp <= 1'b1;
    @(posedge clk);
    load_sp <= 1'b0;
    repeat (6) @(posedge clk);
    check("halt release", 1, hrel);
    repeat (20) @(posedge clk);
    check("vector", 32'h0100, {16'h0, vtk});
    rd(wdnmi_pkg::STS_ADDR, 32'h1, "sts");
    bus(1'b1, wdnmi_pkg::MSK_ADDR, 32'h0);
    bus(1'b1, wdnmi_pkg::STS_ADDR, 32'h1);
    ack_wait <= 4'h0;
    wait_ev(2, 4094, 4099);
    check("masked irq", 0, irq);
    bus(1'b1, wdnmi_pkg::MSK_ADDR, 32'h1);
    @(posedge clk);
    check("irq", 1, irq);
    bus(1'b1, wdnmi_pkg::STS_ADDR, 32'h1);
    @(posedge clk);
    check("irq cleared", 0, irq);
    bus(1'b1, wdnmi_pkg::CTRL_ADDR, 32'h0);
    m_en = 0;
    repeat (9000) @(posedge clk);
    check("disabled", 1, {irq, taken == 2});
    rd(wdnmi_pkg::CTRL_ADDR, 32'h0, "ctrl");
    complete_run();
  end
endmodule : watchdog_nmi_timer_tb_top
`default_nettype wire

//--- wdnmi_cpu_model.sv
// Purpose: cpu core model that takes the watchdog nmi
// Assumes: one clock, synchronous active-high reset
// Notes: ack wait is chosen by the bench, so prompt and slow cpus are tried
`timescale 1ns/10ps
`default_nettype none
module wdnmi_cpu_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_nmi_request,
  input wire logic [15:0] i_nmi_vector,
  input wire logic i_load_sp,
  input wire logic [3:0] i_ack_wait,
  output logic o_sp1_wr,
  output logic o_sp2_wr,
  output logic o_nmi_ack,
  output logic [15:0] o_vector_taken,
  output int o_taken
);
  logic [3:0] wait_ff;
  // ---------------------------------------------------------------
  // core
  // ---------------------------------------------------------------
  // no interrupt-enable flag is consulted: the nmi cannot be masked
  always_ff @(posedge i_clk) begin
    o_sp1_wr <= i_load_sp & ~i_reset;
    o_sp2_wr <= o_sp1_wr;
    o_nmi_ack <= 1'b0;
    if (i_reset) begin
      wait_ff <= 4'h0;
      o_taken <= 0;
      o_vector_taken <= 16'h0000;
    end else if (i_nmi_request && !o_nmi_ack) begin
      if (wait_ff == i_ack_wait) begin
        o_nmi_ack <= 1'b1;
        o_taken <= o_taken + 1;
        o_vector_taken <= i_nmi_vector;
        wait_ff <= 4'h0;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end else begin
      wait_ff <= 4'h0;
    end
  end
endmodule : wdnmi_cpu_model
`default_nettype wire

//--- wdnmi_pkg.sv
// Purpose: shared constants and types of the watchdog nmi timer
// Assumes: 32-bit AHB-Lite register bus, one clock
// Notes: register indices are scaled by four to form byte addresses
`default_nettype none
package wdnmi_pkg;
  // ---------------------------------------------------------------
  // counting
  // ---------------------------------------------------------------
  localparam int unsigned SLOW_OSC_HZ = 32768;
  localparam int unsigned TICK_HZ = 256;
  localparam int unsigned PRESC_DIV = SLOW_OSC_HZ / TICK_HZ;
  localparam int unsigned PRESC_W = $clog2(PRESC_DIV);
  localparam int unsigned CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;
  localparam logic [15:0] NMI_VECTOR = 16'h0100;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL_IDX = 32'h0000FF07;
  localparam logic [31:0] STS_IDX = 32'h0000FF08;
  localparam logic [31:0] MSK_IDX = 32'h0000FF09;
  localparam logic [31:0] CTRL_ADDR = {CTRL_IDX[29:0], 2'b00};
  localparam logic [31:0] STS_ADDR = {STS_IDX[29:0], 2'b00};
  localparam logic [31:0] MSK_ADDR = {MSK_IDX[29:0], 2'b00};
  localparam int unsigned CTRL_CLR_BIT = 0;
  localparam int unsigned CTRL_EN_BIT = 1;
  localparam int unsigned EV_TIMEOUT_BIT = 0;
  localparam logic EN_RESET = 1'b1;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CTRL = 2'h1;
  localparam logic [1:0] SEL_STS = 2'h2;
  localparam logic [1:0] SEL_MSK = 2'h3;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic [PRESC_W-1:0] presc;
    logic [CNT_W-1:0] cnt;
    logic en;
    logic ev_sts;
    logic ev_msk;
    logic nmi_pend;
    logic sp1_seen;
    logic sp2_seen;
    logic sp_ok;
    logic dp_wr;
    logic [1:0] dp_sel;
    logic [31:0] rdata;
  } wdnmi_state_t;
  localparam wdnmi_state_t ST_RESET = '{en: EN_RESET, default: '0};
endpackage : wdnmi_pkg
`default_nettype wire

//--- wdnmi_top.sv
// Purpose: watchdog that raises a non-maskable interrupt on timeout
// Assumes: slow oscillator pin is asynchronous to i_clk
// Notes: zero-wait AHB-Lite slave, always OKAY
//
// Function
// R1: the counter steps on a 256 Hz tick divided from the slow oscillator.
// R2: counting starts right after reset and software may stop it later.
// R3: a timeout nmi follows when no clear came for 3 to 4 s of counting.
// R4: the timeout is the overflow of a 10-bit binary counter.
// R5: counting goes on in halt and the nmi releases the cpu from halt.
// R6: the nmi is taken regardless of the cpu interrupt enable flag.
// R7: the nmi is held back until both stack pointer halves are written.
// R8: the nmi vector is program address 0100H.
// R9: control bit D1 is a read/write enable; 0 stops counting and nmi.
// R10: the enable bit is 1 after reset.
// R11: writing 1 to bit D0 zeroes the counter, writing 0 does nothing.
// R12: bit D0 always reads 0.
// R13: bits D3 and D2 read 0 and hold nothing.
// R14: software clears the watchdog at least every 3 s.
// R15: software not using the watchdog disables it soon after reset.
// R16: one request per overflow; the counter wraps to zero and goes on.
`timescale 1ns/10ps
`default_nettype none
module wdnmi_top #(
  parameter int unsigned PRESC_DIV = wdnmi_pkg::PRESC_DIV
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_low_speed_oscillator,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_stack_pointer_one_wr,
  input wire logic i_stack_pointer_two_wr,
  input wire logic i_nmi_ack,
  output logic o_nmi_request,
  output logic o_halt_release,
  output logic [15:0] o_nmi_vector,
  output logic o_irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam logic [wdnmi_pkg::PRESC_W-1:0] PRESC_LAST =
    wdnmi_pkg::PRESC_W'(PRESC_DIV - 1);
  wdnmi_pkg::wdnmi_state_t st_ff;
  wdnmi_pkg::wdnmi_state_t nxt_st;
  logic osc_rise;
  logic tick;
  logic ovf;
  logic clr;
  logic take;
  logic [1:0] sel;

  always_comb begin
    nxt_st = st_ff;
    tick = 1'b0;
    ovf = 1'b0;
    clr = 1'b0;
    sel = wdnmi_pkg::SEL_NONE;
    // slow oscillator: two flops, then edge detect on the third
    nxt_st.osc_s1 = i_low_speed_oscillator;
    nxt_st.osc_s2 = st_ff.osc_s1;
    nxt_st.osc_s3 = st_ff.osc_s2;
    osc_rise = st_ff.osc_s2 & ~st_ff.osc_s3;
    // prescaler free-runs, so a clear leaves up to one tick of slack
    if (osc_rise) begin
      if (st_ff.presc == PRESC_LAST) begin
        nxt_st.presc = '0;
        tick = 1'b1; // [R1]
      end else begin
        nxt_st.presc = st_ff.presc + 1'b1;
      end
    end
    // control write in the data phase
    if (st_ff.dp_wr && st_ff.dp_sel == wdnmi_pkg::SEL_CTRL) begin
      nxt_st.en = i_hwdata[wdnmi_pkg::CTRL_EN_BIT]; // [R9] [R2]
      clr = i_hwdata[wdnmi_pkg::CTRL_CLR_BIT]; // [R11]
    end
    if (st_ff.dp_wr && st_ff.dp_sel == wdnmi_pkg::SEL_MSK) begin
      nxt_st.ev_msk = i_hwdata[wdnmi_pkg::EV_TIMEOUT_BIT];
    end
    if (st_ff.dp_wr && st_ff.dp_sel == wdnmi_pkg::SEL_STS &&
        i_hwdata[wdnmi_pkg::EV_TIMEOUT_BIT]) begin
      nxt_st.ev_sts = 1'b0;
    end
    // counter: halt does not gate it
    if (clr) begin
      nxt_st.cnt = '0; // [R11]
    end else if (st_ff.en && tick) begin // [R9] [R5]
      nxt_st.cnt = st_ff.cnt + 1'b1; // [R4] [R16]
      ovf = (st_ff.cnt == wdnmi_pkg::CNT_MAX); // [R3] [R4]
    end
    // set wins over clear on both flags
    if (i_nmi_ack) begin
      nxt_st.nmi_pend = 1'b0;
    end
    if (ovf) begin
      nxt_st.nmi_pend = 1'b1; // [R16]
      nxt_st.ev_sts = 1'b1;
    end
    // stack pointer pairing
    if (i_stack_pointer_one_wr || i_stack_pointer_two_wr) begin
      nxt_st.sp_ok = 1'b0; // [R7]
      nxt_st.sp1_seen = st_ff.sp1_seen | i_stack_pointer_one_wr;
      nxt_st.sp2_seen = st_ff.sp2_seen | i_stack_pointer_two_wr;
      if (nxt_st.sp1_seen && nxt_st.sp2_seen) begin
        nxt_st.sp_ok = 1'b1; // [R7]
        nxt_st.sp1_seen = 1'b0;
        nxt_st.sp2_seen = 1'b0;
      end
    end
    // ---------------------------------------------------------------
    // bus address phase
    // ---------------------------------------------------------------
    take = i_hsel & i_htrans[1] & i_hready;
    if (i_haddr == wdnmi_pkg::CTRL_ADDR) begin
      sel = wdnmi_pkg::SEL_CTRL;
    end else if (i_haddr == wdnmi_pkg::STS_ADDR) begin
      sel = wdnmi_pkg::SEL_STS;
    end else if (i_haddr == wdnmi_pkg::MSK_ADDR) begin
      sel = wdnmi_pkg::SEL_MSK;
    end
    nxt_st.dp_wr = take & i_hwrite;
    nxt_st.dp_sel = take ? sel : wdnmi_pkg::SEL_NONE;
    // read data from post-write values so write-then-read sees the write
    nxt_st.rdata = '0;
    if (take && !i_hwrite) begin
      if (sel == wdnmi_pkg::SEL_CTRL) begin
        nxt_st.rdata[wdnmi_pkg::CTRL_EN_BIT] = nxt_st.en; // [R12] [R13]
      end else if (sel == wdnmi_pkg::SEL_STS) begin
        nxt_st.rdata[wdnmi_pkg::EV_TIMEOUT_BIT] = nxt_st.ev_sts;
      end else if (sel == wdnmi_pkg::SEL_MSK) begin
        nxt_st.rdata[wdnmi_pkg::EV_TIMEOUT_BIT] = nxt_st.ev_msk;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_ff <= wdnmi_pkg::ST_RESET; // [R10] [R2]
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = st_ff.rdata;
  // no interrupt-enable input on purpose: the request cannot be masked
  assign o_nmi_request = st_ff.nmi_pend & st_ff.sp_ok; // [R6] [R7]
  assign o_halt_release = o_nmi_request; // [R5]
  assign o_nmi_vector = wdnmi_pkg::NMI_VECTOR; // [R8]
  assign o_irq = st_ff.ev_sts & st_ff.ev_msk;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  property p_tick_from_osc;
    tick |-> osc_rise && st_ff.presc == PRESC_LAST;
  endproperty
  a_tick_from_osc: assert property (p_tick_from_osc) // [R1]
    else $error("tick without prescaler wrap");

  property p_start_after_reset;
    $past(i_reset) |-> st_ff.en && st_ff.cnt == '0;
  endproperty
  a_start_after_reset: assert property (p_start_after_reset) // [R10]
    else $error("watchdog not enabled after reset");

  property p_overflow_sets;
    ovf |=> st_ff.nmi_pend && st_ff.ev_sts && st_ff.cnt == '0;
  endproperty
  a_overflow_sets: assert property (p_overflow_sets) // [R16]
    else $error("overflow did not raise request and wrap");

  property p_overflow_cause;
    ovf |-> tick && st_ff.en && st_ff.cnt == wdnmi_pkg::CNT_MAX && !clr;
  endproperty
  a_overflow_cause: assert property (p_overflow_cause) // [R4]
    else $error("overflow at wrong count");

  property p_hold_without_tick;
    !clr && !(tick && st_ff.en) |=> st_ff.cnt == $past(st_ff.cnt);
  endproperty
  a_hold_without_tick: assert property (p_hold_without_tick) // [R9]
    else $error("counter moved while idle or disabled");

  property p_clear_zeroes;
    clr |=> st_ff.cnt == '0;
  endproperty
  a_clear_zeroes: assert property (p_clear_zeroes) // [R11]
    else $error("clear strobe did not zero counter");

  property p_ctrl_read;
    $past(take && !i_hwrite && sel == wdnmi_pkg::SEL_CTRL && !i_reset) |->
      o_hrdata == {30'h0, st_ff.en, 1'b0};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) // [R12] [R13]
    else $error("control read shows wrong bits");

  property p_sp_gate;
    (i_stack_pointer_one_wr ^ i_stack_pointer_two_wr) &&
      !st_ff.sp1_seen && !st_ff.sp2_seen |=> !o_nmi_request;
  endproperty
  a_sp_gate: assert property (p_sp_gate) // [R7]
    else $error("nmi offered before stack pointer pair");

  property p_nmi_offered;
    st_ff.nmi_pend && st_ff.sp_ok |-> o_nmi_request && o_halt_release &&
      o_nmi_vector == 16'h0100;
  endproperty
  a_nmi_offered: assert property (p_nmi_offered) // [R6] [R5] [R8]
    else $error("pending nmi not offered");

  property p_pend_holds;
    st_ff.nmi_pend && !i_nmi_ack |=> st_ff.nmi_pend;
  endproperty
  a_pend_holds: assert property (p_pend_holds) // [R3]
    else $error("nmi dropped without acknowledge");

  // prescaler and counter stepping
  property p_presc_step;
    osc_rise && st_ff.presc != PRESC_LAST |=>
      st_ff.presc == $past(st_ff.presc) + 1'b1;
  endproperty
  a_presc_step: assert property (p_presc_step) // [R1]
    else $error("prescaler did not step on slow edge");

  property p_presc_hold;
    !osc_rise |=> st_ff.presc == $past(st_ff.presc);
  endproperty
  a_presc_hold: assert property (p_presc_hold) // [R1]
    else $error("prescaler moved without slow edge");

  property p_tick_steps;
    tick && st_ff.en && !clr |=> st_ff.cnt == $past(st_ff.cnt) + 10'h001;
  endproperty
  a_tick_steps: assert property (p_tick_steps) // [R4]
    else $error("counter did not step by one on tick");

  // control register writes
  property p_enable_write;
    st_ff.dp_wr && st_ff.dp_sel == wdnmi_pkg::SEL_CTRL |=>
      st_ff.en == $past(i_hwdata[wdnmi_pkg::CTRL_EN_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write) // [R9]
    else $error("enable bit not taken from write data");

  property p_zero_write_noop;
    st_ff.dp_wr && st_ff.dp_sel == wdnmi_pkg::SEL_CTRL &&
      !i_hwdata[wdnmi_pkg::CTRL_CLR_BIT] && !(tick && st_ff.en) |=>
      st_ff.cnt == $past(st_ff.cnt);
  endproperty
  a_zero_write_noop: assert property (p_zero_write_noop) // [R11]
    else $error("writing zero to clear bit moved counter");

  // a disabled watchdog neither counts nor raises a request
  property p_disabled_quiet;
    !st_ff.en && !clr |=>
      st_ff.cnt == $past(st_ff.cnt) && !$rose(st_ff.nmi_pend);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) // [R9]
    else $error("disabled watchdog counted or raised nmi");

  // request bookkeeping
  property p_pend_cause;
    $rose(st_ff.nmi_pend) |-> $past(ovf);
  endproperty
  a_pend_cause: assert property (p_pend_cause) // [R3]
    else $error("nmi pending without counter overflow");

  property p_ack_clears;
    st_ff.nmi_pend && i_nmi_ack && !ovf |=> !st_ff.nmi_pend;
  endproperty
  a_ack_clears: assert property (p_ack_clears) // [R16]
    else $error("acknowledged nmi stayed pending");

  property p_overflow_once;
    ovf |=> !ovf;
  endproperty
  a_overflow_once: assert property (p_overflow_once) // [R16]
    else $error("overflow flagged on two cycles in a row");

  property p_sp_pair;
    $rose(st_ff.sp_ok) |->
      $past(st_ff.sp1_seen || i_stack_pointer_one_wr) &&
      $past(st_ff.sp2_seen || i_stack_pointer_two_wr);
  endproperty
  a_sp_pair: assert property (p_sp_pair) // [R7]
    else $error("stack pointer pair flag set before both halves");
endmodule : wdnmi_top
`default_nettype wire
